// ### design/ctl_port_pkg.sv
package ctl_port_pkg;
    // two-wire address: fixed upper five bits, then two strap bits
    localparam logic [4:0] I2C_ADDR_HI = 5'h0e;
    localparam logic [6:0] SPI_CHIP_ADDR = 7'h00;
    localparam logic [1:0] SPI_ENTRY_FALLS = 2'h3;
    // subaddress areas, each with its word length in bytes
    localparam logic [15:0] AREA_MEM_END = 16'hc000;
    localparam logic [15:0] AREA_WIDE_END = 16'he000;
    localparam logic [15:0] AREA_REG_END = 16'hf800;
    localparam logic [15:0] AREA_BYTE_END = 16'hfc00;
    localparam logic [2:0] WLEN_MEM = 3'h4;
    localparam logic [2:0] WLEN_WIDE = 3'h5;
    localparam logic [2:0] WLEN_REG = 3'h2;
    localparam logic [2:0] WLEN_BYTE = 3'h1;
    localparam logic [2:0] WLEN_BAD = 3'h0;
    localparam int WR_BUF_DEPTH = 2;

    typedef enum logic [2:0] {EV_NONE, EV_SUB_HI, EV_SUB_LO, EV_WDATA, EV_RDONE} ev_kind_t;
    typedef struct packed {
        ev_kind_t kind;
        logic [7:0] data;
    } byte_ev_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [2:0] lane;
    } loc_t;
    typedef struct packed {
        loc_t loc;
        logic [7:0] data;
    } wr_word_t;
endpackage

// ### design/bit_sync.sv
`timescale 1ns/100ps
module bit_sync #(
    parameter int W = 1
) (
    input wire logic clock,          // destination clock
    input wire logic rst_n,          // async reset, active low
    input wire logic [W-1:0] d,      // foreign level
    output logic [W-1:0] q           // synchronised level
);
    logic [W-1:0] m_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            m_q <= '0;
            q <= '0;
        end else begin
            m_q <= d;
            q <= m_q;
        end
    end
endmodule

// ### design/pair_buffer.sv
`timescale 1ns/100ps
module pair_buffer #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clock,          // system clock
    input wire logic rst_n,          // async reset, active low
    input wire logic in_valid,       // word offered
    output logic in_ready,           // room for a word
    input wire logic [W-1:0] in_data, // offered word
    output logic out_valid,          // word available
    input wire logic out_ready,      // sink takes word
    output logic [W-1:0] out_data    // oldest word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] cnt_q;
    logic push, pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == LAST) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == LAST) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_buf_full_stall: assert property (@(posedge clock) disable iff (!rst_n)
        (cnt_q == (AW+1)'(DEPTH)) && !out_ready |=> !in_ready && $stable(out_data))
        else $error("buffer accepted a word while full");
endmodule

// ### design/ctl_slave_port.sv
`timescale 1ns/100ps
// Behaviour
// - acknowledge each addressed two-wire byte, except an invalid subaddress, by pulling data low on ninth pulse
// - decode word length from subaddress, advance subaddress after each whole word
// - after read address, drive bytes; host acknowledges each on ninth pulse
// - start in two-wire mode; third select fall switches to SPI for good
// - never acknowledge or act on the three entry dummy writes
// - SPI mode holds until hardware reset or power cycle
// - SPI mode 3: sample input on rising, shift output on falling edge
// - SPI output stays released until a read is requested
// - every SPI byte travels most significant bit first
// - first SPI byte holds chip address zero and direction bit in LSB
// - bytes one and two carry subaddress high first, data from byte three
// - on SPI read, drive output from start of byte three
// - two-wire address is 01110 followed by both address pins
// - invalid subaddress gets no acknowledge and the two-wire port goes idle; SPI mode still passes its writes on
// - out-of-sequence start or stop abandons the transfer at once
module ctl_slave_port (
    input wire logic clock,                     // system clock
    input wire logic nrst,                      // async reset, active low
    input wire logic sclk,                      // serial clock from host
    input wire logic select_or_addr_bit0_pin,   // select / address strap 0
    input wire logic serial_in_or_addr_bit1_pin, // serial in / address strap 1
    input wire logic sda_i,                     // data pin level
    output logic sda_o,                         // data pin drive value
    output logic sda_oe,                        // data pin driven
    output logic scl_o,                         // clock pin drive value
    output logic scl_oe,                        // clock held low (stretch)
    output logic spi_mode,                      // port works as SPI slave
    output logic wr_valid,                      // write word available
    input wire logic wr_ready,                  // internal side takes it
    output ctl_port_pkg::wr_word_t wr_word,     // address, lane and byte
    output ctl_port_pkg::loc_t rd_loc,          // location being read
    input wire logic [7:0] rd_data              // byte at rd_loc
);
    import ctl_port_pkg::*;

    typedef enum {S_IDLE, S_ADDR, S_DATA, S_WAIT, S_ACK, S_TX, S_HACK} i2c_st_t;

    function automatic logic [2:0] word_len(input logic [15:0] a);
        if (a < AREA_MEM_END) word_len = WLEN_MEM;
        else if (a < AREA_WIDE_END) word_len = WLEN_WIDE;
        else if (a < AREA_REG_END) word_len = WLEN_REG;
        else if (a < AREA_BYTE_END) word_len = WLEN_BYTE;
        else word_len = WLEN_BAD;
    endfunction

    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    logic rst_n;
    logic scl_s, sda_s, ss_s, a1_s, tgl_s;
    logic scl_p, sda_p, ss_p, tgl_p;
    logic spi_tgl_q;

    bit_sync #(.W(1)) rst_sync (
        .clock(clock),
        .rst_n(nrst),
        .d(1'b1),
        .q(rst_n)
    );

    bit_sync #(.W(5)) pin_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d({sclk, sda_i, select_or_addr_bit0_pin, serial_in_or_addr_bit1_pin, spi_tgl_q}),
        .q({scl_s, sda_s, ss_s, a1_s, tgl_s})
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {scl_p, sda_p, ss_p, tgl_p} <= '0;
        end else begin
            {scl_p, sda_p, ss_p, tgl_p} <= {scl_s, sda_s, ss_s, tgl_s};
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop, ss_fall, ss_rise;
    assign scl_rise = scl_s && !scl_p;
    assign scl_fall = !scl_s && scl_p;
    assign bus_start = scl_s && scl_p && sda_p && !sda_s;
    assign bus_stop = scl_s && scl_p && !sda_p && sda_s;
    assign ss_fall = ss_p && !ss_s;
    assign ss_rise = !ss_p && ss_s;

    // ------------------------------------------------------------
    // mode switch
    // ------------------------------------------------------------
    logic [1:0] falls_q;
    logic spi_mode_q, spi_live_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            falls_q <= '0;
            spi_mode_q <= 1'b0;
            spi_live_q <= 1'b0;
        end else begin
            if (!spi_mode_q && ss_fall) begin
                if (falls_q == SPI_ENTRY_FALLS - 2'h1) spi_mode_q <= 1'b1;
                else falls_q <= falls_q + 2'h1;
            end
            // the frame in flight at the switch is a dummy write: wait for its end
            if (spi_mode_q && ss_rise) spi_live_q <= 1'b1;
        end
    end
    assign spi_mode = spi_mode_q;

    // ------------------------------------------------------------
    // SPI link logic on the host clock
    // ------------------------------------------------------------
    logic spi_rst_n;
    logic [2:0] sbit_q;
    logic [1:0] sidx_q;
    logic [6:0] ssh_q;
    logic srw_q, sok_q, miso_oe_q;
    logic [7:0] miso_sr_q, tx_q;
    byte_ev_t spi_ev_q;
    logic [7:0] sbyte;
    ev_kind_t skind;

    // select high holds the whole link side in reset
    assign spi_rst_n = nrst && !select_or_addr_bit0_pin;
    assign sbyte = {ssh_q, serial_in_or_addr_bit1_pin};

    always_comb begin
        skind = EV_NONE;
        if (sidx_q != 2'h0 && sok_q) begin
            case (sidx_q)
                2'h1: skind = EV_SUB_HI;
                2'h2: skind = EV_SUB_LO;
                default: skind = srw_q ? EV_RDONE : EV_WDATA;
            endcase
        end
    end

    always_ff @(posedge sclk or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            sbit_q <= '0;
            sidx_q <= '0;
            ssh_q <= '0;
            srw_q <= 1'b0;
            sok_q <= 1'b0;
            spi_ev_q <= '{EV_NONE, 8'h00};
            spi_tgl_q <= 1'b0;
        end else begin
            sbit_q <= sbit_q + 3'h1;
            ssh_q <= sbyte[6:0];
            if (sbit_q == 3'h7) begin
                if (sidx_q != 2'h3) sidx_q <= sidx_q + 2'h1;
                if (sidx_q == 2'h0) begin
                    srw_q <= sbyte[0];
                    sok_q <= (sbyte[7:1] == SPI_CHIP_ADDR);
                end
                spi_ev_q <= '{skind, sbyte};
                spi_tgl_q <= !spi_tgl_q;
            end
        end
    end

    // tx_q is settled well before the falling edge that loads it
    always_ff @(negedge sclk or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            miso_sr_q <= '0;
            miso_oe_q <= 1'b0;
        end else if (sbit_q == 3'h0 && sidx_q == 2'h3 && srw_q && sok_q) begin
            miso_sr_q <= tx_q;
            miso_oe_q <= 1'b1;
        end else begin
            miso_sr_q <= {miso_sr_q[6:0], 1'b0};
        end
    end

    a_miso_only_read: assert property (@(negedge sclk) disable iff (!spi_rst_n)
        miso_oe_q |-> srw_q && sok_q && sidx_q == 2'h3)
        else $error("output driven outside a read data phase");

    // ------------------------------------------------------------
    // byte events and subaddress tracking
    // ------------------------------------------------------------
    i2c_st_t st_q;
    logic [3:0] bits_q;
    logic [7:0] sh_q;
    logic rw_q, ack_q, hack_q, i2c_oe_q;
    logic [1:0] dcnt_q;
    logic i2c_post, spi_new, ev_pend_q, take, buf_ready;
    byte_ev_t ev_q, i2c_ev;
    logic [15:0] addr_q;
    logic [7:0] hi_q;
    logic [2:0] bcnt_q, wlen;
    logic bad_q;

    assign spi_new = spi_live_q && (tgl_s != tgl_p);
    assign i2c_post = scl_fall && ((st_q == S_DATA && bits_q == 4'h8)
                                   || (st_q == S_TX && bits_q == 4'h7));
    assign i2c_ev.kind = (st_q == S_TX) ? EV_RDONE :
                         (dcnt_q == 2'h0) ? EV_SUB_HI :
                         (dcnt_q == 2'h1) ? EV_SUB_LO : EV_WDATA;
    assign i2c_ev.data = sh_q;
    assign take = ev_pend_q && (ev_q.kind != EV_WDATA || buf_ready);
    assign wlen = word_len(addr_q);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ev_pend_q <= 1'b0;
            ev_q <= '{EV_NONE, 8'h00};
        end else if (spi_new) begin
            ev_q <= spi_ev_q;
            ev_pend_q <= (spi_ev_q.kind != EV_NONE);
        end else if (i2c_post && !spi_mode_q) begin
            ev_q <= i2c_ev;
            ev_pend_q <= 1'b1;
        end else if (take) begin
            ev_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
            hi_q <= '0;
            bcnt_q <= '0;
            bad_q <= 1'b0;
        end else if (take) begin
            case (ev_q.kind)
                EV_SUB_HI: hi_q <= ev_q.data;
                EV_SUB_LO: begin
                    addr_q <= {hi_q, ev_q.data};
                    bcnt_q <= '0;
                    bad_q <= (word_len({hi_q, ev_q.data}) == WLEN_BAD);
                end
                EV_WDATA, EV_RDONE: begin
                    if (bcnt_q >= wlen - 3'h1) begin
                        addr_q <= addr_q + 16'h0001;
                        bcnt_q <= '0;
                    end else begin
                        bcnt_q <= bcnt_q + 3'h1;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) tx_q <= '0;
        else tx_q <= rd_data;
    end
    assign rd_loc = '{addr_q, bcnt_q};

    pair_buffer #(.W($bits(wr_word_t)), .DEPTH(WR_BUF_DEPTH)) wr_buf (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(ev_pend_q && ev_q.kind == EV_WDATA),
        .in_ready(buf_ready),
        .in_data({addr_q, bcnt_q, ev_q.data}),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_word)
    );

    a_word_advance: assert property (@(posedge clock) disable iff (!rst_n)
        take && ev_q.kind == EV_WDATA && bcnt_q == wlen - 3'h1
        |=> addr_q == $past(addr_q) + 16'h0001 && bcnt_q == 3'h0)
        else $error("subaddress did not advance after a whole word");
    a_word_hold: assert property (@(posedge clock) disable iff (!rst_n)
        take && (ev_q.kind == EV_WDATA || ev_q.kind == EV_RDONE) && bcnt_q < wlen - 3'h1
        |=> $stable(addr_q) && bcnt_q == $past(bcnt_q) + 3'h1)
        else $error("subaddress moved inside a word");

    // ------------------------------------------------------------
    // two-wire engine
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= S_IDLE;
            bits_q <= '0;
            sh_q <= '0;
            rw_q <= 1'b0;
            ack_q <= 1'b0;
            hack_q <= 1'b0;
            i2c_oe_q <= 1'b0;
            dcnt_q <= '0;
        end else if (spi_mode_q) begin
            st_q <= S_IDLE;
            i2c_oe_q <= 1'b0;
        end else if (bus_start) begin
            st_q <= S_ADDR;
            bits_q <= '0;
            i2c_oe_q <= 1'b0;
        end else if (bus_stop) begin
            st_q <= S_IDLE;
            i2c_oe_q <= 1'b0;
        end else begin
            case (st_q)
                S_ADDR, S_DATA: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_s};
                        bits_q <= bits_q + 4'h1;
                    end else if (scl_fall && bits_q == 4'h8) begin
                        if (st_q == S_DATA) begin
                            st_q <= S_WAIT;
                        end else if (sh_q[7:1] == {I2C_ADDR_HI, a1_s, ss_s}) begin
                            rw_q <= sh_q[0];
                            if (!sh_q[0]) dcnt_q <= '0;
                            ack_q <= 1'b1;
                            i2c_oe_q <= 1'b1;
                            st_q <= S_ACK;
                        end else begin
                            st_q <= S_IDLE;
                        end
                    end
                end
                S_WAIT: begin
                    if (!ev_pend_q) begin
                        ack_q <= !(dcnt_q == 2'h1 && bad_q);
                        i2c_oe_q <= !(dcnt_q == 2'h1 && bad_q);
                        if (dcnt_q != 2'h2) dcnt_q <= dcnt_q + 2'h1;
                        st_q <= S_ACK;
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        bits_q <= '0;
                        if (!ack_q) begin
                            i2c_oe_q <= 1'b0;
                            st_q <= S_IDLE;
                        end else if (rw_q) begin
                            sh_q <= tx_q;
                            i2c_oe_q <= !tx_q[7];
                            st_q <= S_TX;
                        end else begin
                            i2c_oe_q <= 1'b0;
                            st_q <= S_DATA;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        if (bits_q == 4'h7) begin
                            i2c_oe_q <= 1'b0;
                            st_q <= S_HACK;
                        end else begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            i2c_oe_q <= !sh_q[6];
                            bits_q <= bits_q + 4'h1;
                        end
                    end
                end
                S_HACK: begin
                    if (scl_rise) begin
                        hack_q <= !sda_s;
                    end else if (scl_fall) begin
                        bits_q <= '0;
                        if (hack_q) begin
                            sh_q <= tx_q;
                            i2c_oe_q <= !tx_q[7];
                            st_q <= S_TX;
                        end else begin
                            st_q <= S_IDLE;
                        end
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // data shares the pin: open drain in two-wire mode, push-pull in SPI
    assign sda_o = spi_mode_q ? miso_sr_q[7] : 1'b0;
    assign sda_oe = spi_mode_q ? miso_oe_q : i2c_oe_q;
    assign scl_o = 1'b0;
    assign scl_oe = (st_q == S_WAIT);

    sequence s_byte_decided;
        st_q == S_WAIT ##1 st_q == S_ACK;
    endsequence
    sequence s_bad_sub_seen;
        take && ev_q.kind == EV_SUB_LO && word_len({hi_q, ev_q.data}) == WLEN_BAD;
    endsequence

    a_ack_ninth: assert property (@(posedge clock) disable iff (!rst_n)
        s_byte_decided ##0 ack_q |-> !sda_o && sda_oe ##1 !sda_o && sda_oe)
        else $error("acknowledge not driven on ninth pulse");
    a_bad_sub_nack: assert property (@(posedge clock) disable iff (!rst_n)
        s_bad_sub_seen ##2 st_q == S_ACK |-> !ack_q && !sda_oe)
        else $error("invalid subaddress was acknowledged");
    a_stop_abort: assert property (@(posedge clock) disable iff (!rst_n)
        bus_stop && !spi_mode_q |=> st_q == S_IDLE && !i2c_oe_q)
        else $error("stop did not abandon the transfer");
    a_mode_entry: assert property (@(posedge clock) disable iff (!rst_n)
        !spi_mode_q && ss_fall && falls_q == 2'h2 |=> spi_mode_q [*3])
        else $error("third select fall did not enter SPI mode");
    a_mode_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        spi_mode_q |=> spi_mode_q)
        else $error("SPI mode was left without reset");
    a_dummy_ignored: assert property (@(posedge clock) disable iff (!rst_n)
        spi_mode_q && !spi_live_q |-> !ev_pend_q && !wr_valid && !sda_oe)
        else $error("dummy write was acted on");
endmodule

// ### dv/host_model.sv
`timescale 1ns/100ps
module host_model (
    input wire logic scl_line, // clock pin level
    input wire logic sda_line, // data pin level
    output logic scl_drv,      // clock released high when 1
    output logic sda_low,      // host pulls data low
    output logic sel,          // select / strap 0
    output logic mosi          // serial in / strap 1
);
    initial begin
        scl_drv = 1'b1;
        sda_low = 1'b0;
        sel = 1'b1;
        mosi = 1'b0;
    end
    // ----
    // two-wire master
    // ----
    task automatic tw_bit(input logic b, output logic r);
        scl_drv = 1'b0;
        #40 sda_low = !b;
        #40 scl_drv = 1'b1;
        // wait out clock stretch
        for (int i = 0; i < 400 && !scl_line; i++) #8;
        r = sda_line;
        #80;
    endtask
    task automatic tw_start();
        scl_drv = 1'b0;
        #40 sda_low = 1'b0;
        #40 scl_drv = 1'b1;
        #80 sda_low = 1'b1;
        #80;
    endtask
    task automatic tw_stop();
        scl_drv = 1'b0;
        #40 sda_low = 1'b1;
        #40 scl_drv = 1'b1;
        #80 sda_low = 1'b0;
        #80;
    endtask
    task automatic tw_byte(input logic [7:0] b, input logic k, output logic [7:0] r,
                           output logic a);
        for (int i = 7; i >= 0; i--) tw_bit(b[i], r[i]);
        tw_bit(k, a);
    endtask
    // ----
    // spi master, mode 3
    // ----
    task automatic spi_sel(input logic v);
        #80 sel = v;
        #80;
    endtask
    // address straps, set just before the port is put back in reset
    task automatic set_straps(input logic a1, input logic a0);
        mosi = a1;
        sel = a0;
    endtask
    task automatic spi_byte(input logic [7:0] t, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            scl_drv = 1'b0;
            mosi = t[i];
            #80 scl_drv = 1'b1;
            r[i] = sda_line;
            #80;
        end
    endtask
endmodule

// ### dv/ctl_slave_port_bench.sv
`timescale 1ns/100ps
module ctl_slave_port_bench;
    import ctl_port_pkg::*;
    logic clock, nrst, wr_ready, sda_o, sda_oe, scl_o, scl_oe, spi_mode, wr_valid, a;
    logic scl_drv, sda_low, sel, mosi;
    logic [7:0] rd_data, r, d;
    wr_word_t wr_word;
    loc_t rd_loc;
    wr_word_t exp_q[$];
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;
    wire scl_line = scl_drv & (scl_oe ? scl_o : 1'b1);
    wire sda_line = sda_low ? 1'b0 : (sda_oe ? sda_o : 1'b1);
    ctl_slave_port ctl_slave_port_inst (.clock(clock), .nrst(nrst), .sclk(scl_line),
        .select_or_addr_bit0_pin(sel), .serial_in_or_addr_bit1_pin(mosi),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe),
        .spi_mode(spi_mode), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_word(wr_word), .rd_loc(rd_loc), .rd_data(rd_data));
    host_model host_model_inst (.scl_line(scl_line), .sda_line(sda_line),
        .scl_drv(scl_drv), .sda_low(sda_low), .sel(sel), .mosi(mosi));
    // ----
    // checking
    // ----
    task automatic cmp(input logic [26:0] g, input logic [26:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        cmp({19'h0, g}, {19'h0, e});
    endtask
    task automatic report_and_stop();
        $display("tests=%0d failures=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic expw(input logic [15:0] ad, input logic [2:0] ln, input logic [7:0] dt);
        exp_q.push_back('{'{ad, ln}, dt});
    endtask
    task automatic twb(input logic [7:0] b, input logic e);
        host_model_inst.tw_byte(b, 1'b1, r, a);
        cmp8({7'h0, a}, {7'h0, e});
    endtask
    task automatic sb(input logic [7:0] t);
        host_model_inst.spi_byte(t, r);
    endtask
    task automatic rst();
        nrst <= 1'b0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        repeat (6) @(posedge clock);
        // keep the host's pin changes off the system clock edges
        #3;
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        rd_data <= rd_loc.addr[7:0] ^ {5'h0, rd_loc.lane} ^ 8'ha5;
        wr_ready <= ($urandom % 4) != 0;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            report_and_stop();
        end
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            cmp(wr_word, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
        end
    end
    // ----
    // scenarios
    // ----
    initial begin
        void'($urandom(32'h4cd16d1e));
        nrst = 1'b0;
        rst();
        host_model_inst.tw_start();
        twb(8'h72, 1'b0);
        twb(8'hf8, 1'b0);
        twb(8'h00, 1'b0);
        for (int i = 0; i < 2; i++) begin
            d = 8'($urandom);
            expw(16'hf800 + 16'(i), 3'h0, d);
            twb(d, 1'b0);
        end
        host_model_inst.tw_stop();
        host_model_inst.tw_start();
        twb(8'h74, 1'b1);
        host_model_inst.tw_stop();
        host_model_inst.tw_start();
        twb(8'h72, 1'b0);
        twb(8'hfc, 1'b0);
        twb(8'h00, 1'b1);
        twb(8'h55, 1'b1);
        host_model_inst.tw_stop();
        host_model_inst.tw_start();
        twb(8'h72, 1'b0);
        twb(8'hf8, 1'b0);
        twb(8'h01, 1'b0);
        host_model_inst.tw_start();
        twb(8'h73, 1'b0);
        host_model_inst.tw_byte(8'hff, 1'b0, r, a);
        cmp8(r, 8'ha4);
        host_model_inst.tw_byte(8'hff, 1'b1, r, a);
        cmp8(r, 8'ha7);
        host_model_inst.tw_stop();
        for (int k = 0; k < 3; k++) begin
            cmp8({7'h0, spi_mode}, 8'h00);
            host_model_inst.spi_sel(1'b0);
            sb(8'h00);
            sb(8'hf8);
            sb(8'h00);
            sb(8'($urandom));
            host_model_inst.spi_sel(1'b1);
        end
        cmp8({7'h0, spi_mode}, 8'h01);
        host_model_inst.spi_sel(1'b0);
        sb(8'h00);
        sb(8'hc0);
        sb(8'h00);
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            expw(i < 5 ? 16'hc000 : 16'hc001, 3'(i % 5), d);
            sb(d);
        end
        host_model_inst.spi_sel(1'b1);
        host_model_inst.spi_sel(1'b0);
        sb(8'h02);
        sb(8'hf8);
        sb(8'h00);
        sb(8'h77);
        host_model_inst.spi_sel(1'b1);
        host_model_inst.spi_sel(1'b0);
        sb(8'h01);
        sb(8'hf8);
        sb(8'h00);
        cmp8({7'h0, sda_oe}, 8'h00);
        sb(8'h00);
        cmp8(r, 8'ha5);
        sb(8'h00);
        cmp8(r, 8'ha4);
        cmp8({7'h0, sda_oe}, 8'h01);
        host_model_inst.spi_sel(1'b1);
        repeat (200) @(posedge clock);
        cmp8(8'(exp_q.size()), 8'h00);
        host_model_inst.set_straps(1'b1, 1'b1);
        rst();
        cmp8({7'h0, spi_mode}, 8'h00);
        host_model_inst.tw_start();
        twb(8'h76, 1'b0);
        host_model_inst.tw_stop();
        host_model_inst.tw_start();
        twb(8'h72, 1'b1);
        host_model_inst.tw_stop();
        report_and_stop();
    end
endmodule
